// file: logic/ffn_normalizer.sv
`timescale 1ns/1ns
// Behaviour
// RULE1 - operand is an 8-bit exponent with a 72-bit fraction mantissa
// RULE2 - mantissa is two's complement fraction, bit 71 weighs minus one
// RULE3 - exponent 10000000 with all-zero mantissa is normalized zero
// RULE4 - operand is normalized whenever the two leading mantissa bits differ
// RULE5 - value is signed mantissa times two to the signed exponent
// RULE6 - plus one is 01/0100..0, minus one is 00/1000..0
// RULE7 - non-power-of-two negation keeps exponent, mantissa two's complemented; code complements only the upper word, lower word passes through
// RULE8 - alignment right shift copies sign bit in, drops bits off the right
// RULE9 - upper, lower and pair registers get numeric and logical right shift
// RULE10 - no negative zero exists; zero is unique and positive
// RULE11 - fixed add and subtract are modulo word width, operands unsigned
// RULE12 - overflow when carry out of sign differs from carry into it
// RULE13 - subtract adds ones complement of subtrahend with carry in one
// RULE14 - all-zero floating result mantissa forces the zero exponent
module ffn_normalizer #(
  parameter int unsigned SHIFT_W = 7
) (
  input  wire logic        CLOCK,
  input  wire logic        RST,
  input  wire logic [6:0]  OP,
  input  wire logic [2:0]  SEL,
  input  wire logic [SHIFT_W-1:0] COUNT,
  input  wire logic [7:0]  EXP_IN,
  input  wire logic [71:0] MAN_IN,
  input  wire logic [71:0] OPERAND,
  output logic      [7:0]  EXP_OUT,
  output logic      [71:0] MAN_OUT,
  output logic             NORMALIZED,
  output logic             NEGATIVE,
  output logic             ZERO,
  output logic             OVERFLOW,
  output logic             CARRY,
  output logic             DONE
);
  initial begin
    if (SHIFT_W < 1 || SHIFT_W > 8) begin
      $error("SHIFT_W out of range");
    end
  end

  localparam int unsigned W = ffn_pkg::WORD_W;

  logic [7:0]  next_exp;
  logic [71:0] next_man;
  logic        next_norm;
  logic        next_neg;
  logic        next_zero;
  logic        next_ovf;
  logic        next_carry;
  logic        next_done;

  // shifts use the full count in one cycle; result equals count repeated
  // single-bit shifts, which is what the sequencer expects
  function automatic logic [W-1:0] shr_w(input logic [W-1:0] v,
                                         input logic [SHIFT_W-1:0] n,
                                         input logic arith);
    logic [W-1:0] r;
    r = v;
    for (int i = 0; i < (1 << SHIFT_W); i++) begin
      if (i < int'(n)) begin
        r = {arith & r[W-1], r[W-1:1]};
      end
    end
    return r;
  endfunction : shr_w

  function automatic logic [71:0] shr_p(input logic [71:0] v,
                                        input logic [SHIFT_W-1:0] n,
                                        input logic arith);
    logic [71:0] r;
    r = v;
    for (int i = 0; i < (1 << SHIFT_W); i++) begin
      if (i < int'(n)) begin
        r = {arith & r[71], r[71:1]};
      end
    end
    return r;
  endfunction : shr_p

  always_comb begin
    logic [71:0] m;
    logic [7:0]  e;
    logic [71:0] b;
    logic        cin;
    logic [W:0]  s_lo;
    logic [W-1:0] s_hi;
    logic [W:0]  s_full;
    logic        c_in_sign;
    m = MAN_IN;                                            // [RULE1]
    e = EXP_IN;
    b = '0;
    cin = 1'b0;
    s_lo = '0;
    s_hi = '0;
    s_full = '0;
    c_in_sign = 1'b0;
    next_ovf = 1'b0;
    next_carry = 1'b0;
    unique case (OP)
      ffn_pkg::FFN_OP_NONE: begin
        m = MAN_IN;
      end
      ffn_pkg::FFN_OP_ALIGN: begin
        m = shr_p(MAN_IN, COUNT, 1'b1);                    // [RULE8]
        e = EXP_IN + {{(8-SHIFT_W){1'b0}}, COUNT};
      end
      ffn_pkg::FFN_OP_NRS, ffn_pkg::FFN_OP_LRS: begin
        unique case (SEL)                                  // [RULE9]
          ffn_pkg::FFN_SEL_UPPER:
            m = {shr_w(MAN_IN[71:36], COUNT, OP[2]), MAN_IN[35:0]};
          ffn_pkg::FFN_SEL_LOWER:
            m = {MAN_IN[71:36], shr_w(MAN_IN[35:0], COUNT, OP[2])};
          default:
            m = shr_p(MAN_IN, COUNT, OP[2]);
        endcase
      end
      ffn_pkg::FFN_OP_ADD, ffn_pkg::FFN_OP_SUB, ffn_pkg::FFN_OP_NEG: begin
        // upper word arithmetic; operands taken as unsigned [RULE11]
        b = (OP == ffn_pkg::FFN_OP_ADD) ? OPERAND : ~OPERAND; // [RULE13]
        cin = (OP != ffn_pkg::FFN_OP_ADD);                 // [RULE13]
        if (OP == ffn_pkg::FFN_OP_NEG) begin
          s_lo = {1'b0, ~MAN_IN[70:36]} + {{W{1'b0}}, 1'b1};
          s_full = {1'b0, ~MAN_IN[71:36]} + {{W{1'b0}}, 1'b1};
        end else begin
          s_lo = {1'b0, MAN_IN[70:36]} + {1'b0, b[70:36]} + {{W{1'b0}}, cin};
          s_full = {1'b0, MAN_IN[71:36]} + {1'b0, b[71:36]}
                 + {{W{1'b0}}, cin};
        end
        c_in_sign = s_lo[W-1];
        s_hi = s_full[W-1:0];
        next_carry = s_full[W];
        next_ovf = s_full[W] ^ c_in_sign;                  // [RULE12]
        // negating zero gives zero again, never a minus zero [RULE10]
        m = {s_hi, MAN_IN[35:0]};                          // [RULE7]
      end
      default: begin
        m = MAN_IN;
      end
    endcase
    // only the float ops own the exponent
    if (m == '0 && (OP == ffn_pkg::FFN_OP_ALIGN
                    || OP == ffn_pkg::FFN_OP_NONE)) begin
      e = ffn_pkg::ZERO_EXP;                               // [RULE14]
    end
    next_exp = e;
    next_man = m;
    // value = m * 2**e, with m's bit 71 weighing -1 [RULE2] [RULE5] [RULE6]
    next_neg = m[71];                                      // [RULE10]
    next_zero = (m == '0);
    next_norm = (m[71] != m[70])                           // [RULE4]
              || (m == '0 && e == ffn_pkg::ZERO_EXP);      // [RULE3]
    next_done = (OP != ffn_pkg::FFN_OP_NONE);
  end

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      EXP_OUT    <= ffn_pkg::ZERO_EXP;
      MAN_OUT    <= '0;
      NORMALIZED <= 1'b1;
      NEGATIVE   <= 1'b0;
      ZERO       <= 1'b1;
      OVERFLOW   <= 1'b0;
      CARRY      <= 1'b0;
      DONE       <= 1'b0;
    end else begin
      EXP_OUT    <= next_exp;
      MAN_OUT    <= next_man;
      NORMALIZED <= next_norm;
      NEGATIVE   <= next_neg;
      ZERO       <= next_zero;
      OVERFLOW   <= next_ovf;
      CARRY      <= next_carry;
      DONE       <= next_done;
    end
  end
endmodule : ffn_normalizer

// file: logic/ffn_pkg.sv
package ffn_pkg;
  localparam int unsigned EXP_W      = 8;
  localparam int unsigned MAN_W      = 72;
  localparam int unsigned WORD_W     = 36;
  localparam logic [7:0]  ZERO_EXP   = 8'h80;
  localparam logic [7:0]  ONE_POS_EXP = 8'h01;
  localparam logic [7:0]  ONE_NEG_EXP = 8'h00;
  localparam logic [71:0] ONE_POS_MAN = 72'h40_0000_0000_0000_0000;
  localparam logic [71:0] ONE_NEG_MAN = 72'h80_0000_0000_0000_0000;

  typedef enum logic [6:0] {
    FFN_OP_NONE  = 7'h01,
    FFN_OP_ALIGN = 7'h02,
    FFN_OP_NRS   = 7'h04,
    FFN_OP_LRS   = 7'h08,
    FFN_OP_ADD   = 7'h10,
    FFN_OP_SUB   = 7'h20,
    FFN_OP_NEG   = 7'h40
  } ffn_op_e;

  typedef enum logic [2:0] {
    FFN_SEL_UPPER = 3'h1,
    FFN_SEL_LOWER = 3'h2,
    FFN_SEL_PAIR  = 3'h4
  } ffn_sel_e;
endpackage : ffn_pkg

// file: verif/ffn_rf_model.sv
`timescale 1ns/1ns
// result register: holds the last finished result, fed back as operand
module ffn_rf_model (
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic        done,
  input  wire logic [79:0] res,
  output logic      [79:0] held
);
  logic [79:0] next_held;
  always_comb next_held = done ? res : held;
  always_ff @(posedge clock or posedge rst) held <= rst ? '0 : next_held;
endmodule : ffn_rf_model

// file: verif/ffn_properties.sv
`timescale 1ns/1ns
module ffn_chk (
  input wire logic        CLOCK,
  input wire logic        RST,
  input wire logic [6:0]  OP,
  input wire logic [71:0] MAN_IN,
  input wire logic [71:0] OPERAND,
  input wire logic [7:0]  EXP_OUT,
  input wire logic [71:0] MAN_OUT,
  input wire logic        NORMALIZED,
  input wire logic        NEGATIVE,
  input wire logic        ZERO,
  input wire logic        OVERFLOW
);
  default clocking @(posedge CLOCK); endclocking
  default disable iff (RST);
  sequence s_op(o);
    !$past(RST) && $past(OP) == o;
  endsequence
  norm_flag_a:
    assert property (NORMALIZED == (MAN_OUT[71] != MAN_OUT[70] ||
      MAN_OUT == 0 && EXP_OUT == 8'h80)) else $error("norm flag");
  zero_flag_a:
    assert property (ZERO == (MAN_OUT == 0)) else $error("zero flag");
  sign_flag_a:
    assert property (NEGATIVE == MAN_OUT[71]) else $error("sign flag");
  align_sign_a:
    assert property (s_op(ffn_pkg::FFN_OP_ALIGN) |->
      MAN_OUT[71] == $past(MAN_IN[71])) else $error("align sign");
  nrs_sign_a:
    assert property (s_op(ffn_pkg::FFN_OP_NRS) |->
      MAN_OUT[71] == $past(MAN_IN[71])) else $error("nrs sign");
  add_ovf_a:
    assert property (s_op(ffn_pkg::FFN_OP_ADD) |-> OVERFLOW ==
      ($past(MAN_IN[71]) == $past(OPERAND[71]) &&
      MAN_OUT[71] != $past(MAN_IN[71]))) else $error("add ovf");
  sub_ovf_a:
    assert property (s_op(ffn_pkg::FFN_OP_SUB) |-> OVERFLOW ==
      ($past(MAN_IN[71]) != $past(OPERAND[71]) &&
      MAN_OUT[71] != $past(MAN_IN[71]))) else $error("sub ovf");
  zero_exp_a:
    assert property (s_op(ffn_pkg::FFN_OP_ALIGN) ##0 MAN_OUT == 0 |->
      EXP_OUT == ffn_pkg::ZERO_EXP) else $error("zero exp");
endmodule : ffn_chk
bind ffn_normalizer ffn_chk chk_u (.*);

// file: verif/tb_float_format_normalizer.sv
`timescale 1ns/1ns
module tb_float_format_normalizer;
  logic clk = 0, rst = 1, nrm, neg, zer, ovf, cy, done;
  logic [6:0] op = 7'h01, cnt = 0;
  logic [2:0] sel = 3'h4;
  logic [7:0] ei = 0, eo;
  logic [71:0] mi = 0, b = 0, mo;
  logic [79:0] held, q[$];
  logic [15:0] r = 16'hed94;
  int bad_count = 0, num_checks = 0;
  initial begin forever #20 clk = ~clk; end
  ffn_normalizer dut_u (.CLOCK(clk), .RST(rst), .OP(op), .SEL(sel),
    .COUNT(cnt), .EXP_IN(ei), .MAN_IN(mi), .OPERAND(b), .EXP_OUT(eo),
    .MAN_OUT(mo), .NORMALIZED(nrm), .NEGATIVE(neg), .ZERO(zer),
    .OVERFLOW(ovf), .CARRY(cy), .DONE(done));
  ffn_rf_model rf_u (.clock(clk), .rst(rst), .done(done), .res({eo, mo}),
    .held(held));
  function logic [71:0] sr(input logic [71:0] x, input logic [6:0] n,
    input logic f);
    return (x >> n) | (f ? ~(~72'h0 >> n) : 72'h0);
  endfunction : sr
  function logic [79:0] model(input logic [6:0] o, input logic [2:0] s,
    input logic [6:0] n, input logic [7:0] e, input logic [71:0] m, x);
    logic a;
    logic [71:0] hi, lo;
    a = o != 7'h08;
    hi = sr({m[71:36], 36'h0}, n, a & m[71]);
    lo = sr({m[35:0], 36'h0}, n, a & m[35]);
    case (o)
      7'h02: begin
        m = sr(m, n, m[71]);
        e = (m == 0) ? 8'h80 : e + {1'b0, n};
      end
      7'h04, 7'h08: m = s[2] ? sr(m, n, a & m[71]) :
        s[0] ? {hi[71:36], m[35:0]} : {m[71:36], lo[71:36]};
      7'h10: m[71:36] = m[71:36] + x[71:36];
      7'h20: m[71:36] = m[71:36] + ~x[71:36] + 36'h1;
      default: m[71:36] = ~m[71:36] + 36'h1;
    endcase
    return {e, m};
  endfunction : model
  task go(input logic [6:0] o, input logic [2:0] s, input logic [6:0] n,
    input logic [7:0] e, input logic [71:0] m, x);
    @(posedge clk);
    op <= o; sel <= s; cnt <= n; ei <= e; mi <= m; b <= x;
    q.push_back(model(o, s, n, e, m, x));
  endtask : go
  task chk(input string nm, input logic [79:0] got, exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask : chk
  task final_report;
    $display("checks %0d bad %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : final_report
  always @(negedge clk) if (done === 1'b1) chk("result", {eo, mo},
    q.pop_front());
  initial begin
    repeat (12) @(posedge clk);
    rst <= 0;
    @(negedge clk);
    chk("reset", {eo, mo}, {8'h80, 72'h0});
    go(7'h02, 3'h4, 0, 8'h01, ffn_pkg::ONE_POS_MAN, 0);
    go(7'h02, 3'h4, 0, 8'h00, ffn_pkg::ONE_NEG_MAN, 0);
    go(7'h40, 3'h4, 0, 8'h04, {8'h50, 64'h0}, 0);
    go(7'h02, 3'h4, 3, 8'hfe, ffn_pkg::ONE_NEG_MAN, 0);
    go(7'h02, 3'h4, 72, 8'h05, ffn_pkg::ONE_POS_MAN, 0);
    go(7'h10, 3'h4, 0, 0, {36'h7ffffffff, 36'h5}, {36'h1, 36'h0});
    go(7'h20, 3'h4, 0, 0, 0, {36'h800000000, 36'h0});
    $display("directed test done");
    repeat (300) begin
      r = lfsr(r);
      go(7'h02 << (r % 6), 3'h1 << (r[9:4] % 3), r[6:0], r[15:8],
        {r, ~r, r ^ 16'h3c3c, r, r[7:0]}, held[71:0]);
    end
    @(posedge clk) op <= 7'h01;
    repeat (3) @(posedge clk);
    $display("random test done");
    final_report;
  end
  function logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr
  initial begin
    #40000;
    bad_count++;
    final_report;
  end
endmodule : tb_float_format_normalizer
